// ### core/sensor_regs_pkg.sv
// register map, field layout and link framing of the id and status block
package sensor_regs_pkg;

    // register addresses on the serial link
    localparam logic [6:0] ADDR_PART_ID_HIGH_BYTE = 7'h00;
    localparam logic [6:0] ADDR_PART_ID_LOW_NIBBLE = 7'h01;
    localparam logic [6:0] ADDR_MOVEMENT_FLAGS = 7'h02;
    localparam logic [6:0] ADDR_DELTA_X = 7'h03;
    localparam logic [6:0] ADDR_DELTA_Y = 7'h04;

    // part identifier split
    localparam int PART_ID_WIDTH = 12;
    localparam int PART_ID_HIGH_MSB = 11;
    localparam int PART_ID_HIGH_LSB = 4;
    localparam int PART_ID_LOW_MSB = 3;
    localparam logic [3:0] PART_ID_RESERVED_NIBBLE = 4'h0;

    // movement_flags layout
    localparam int MOTION_BIT = 7;
    localparam int Y_OVERFLOW_BIT = 4;
    localparam int X_OVERFLOW_BIT = 3;
    localparam int RESOLUTION_LSB = 0;
    localparam int RESOLUTION_WIDTH = 3;
    localparam logic [1:0] FLAGS_RESERVED = 2'h0;

    typedef enum logic [2:0] {
        cpi_400 = 3'b000,
        cpi_500 = 3'b001,
        cpi_600 = 3'b010,
        cpi_800 = 3'b011,
        cpi_1000 = 3'b100,
        cpi_1200 = 3'b101
    } resolution_t;

    localparam resolution_t RESOLUTION_RESET = cpi_1000;

    // delta accumulators
    localparam int AXIS_COUNT = 2;
    localparam int AXIS_X = 0;
    localparam int AXIS_Y = 1;
    localparam logic [7:0] DELTA_RESET = 8'h00;
    localparam logic [7:0] DELTA_MOST_POSITIVE = 8'h7f;
    localparam logic [7:0] DELTA_MOST_NEGATIVE = 8'h80;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // link framing: direction bit then 7 address bits, then 8 data bits
    localparam int DIRECTION_BIT = 6;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
    localparam logic [2:0] BIT_COUNT_RESET = 3'h0;

    typedef enum logic [1:0] {
        ph_addr = 2'b00,
        ph_read = 2'b01,
        ph_write = 2'b10
    } link_phase_t;

endpackage

// ### core/serial_link.sv
// serial link end on the host clock: frames address and data bytes
`timescale 1ns/10ps
`default_nettype none

module serial_link
    import sensor_regs_pkg::*;
(
    input wire logic sclk,
    input wire logic rst,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic [6:0] read_addr,
    output logic read_req_toggle,
    input wire logic [7:0] read_data
);

    logic rst_meta;
    logic link_rst;
    link_phase_t phase;
    logic [2:0] bit_cnt;
    logic [6:0] shift;

    wire logic [7:0] next_shift = {shift, sdio_in};
    wire logic last_bit = (bit_cnt == LAST_BIT_INDEX);
    wire logic is_read = ~next_shift[7];
    wire logic [2:0] out_index = ~bit_cnt;

    ////////////////////////////////////////////////////////////////////////
    // reset brought onto the link clock
    always_ff @(posedge sclk)
    begin
        rst_meta <= rst;
        link_rst <= rst_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // sampling on rising edges
    always_ff @(posedge sclk)
    begin
        if (link_rst)
        begin
            phase <= ph_addr;
            bit_cnt <= BIT_COUNT_RESET;
            shift <= 7'h00;
            read_addr <= 7'h00;
            read_req_toggle <= 1'b0;
        end
        else
        begin
            bit_cnt <= bit_cnt + 3'h1;
            case (phase)
                ph_addr:
                begin
                    shift <= next_shift[6:0];
                    if (last_bit && is_read)
                    begin
                        phase <= ph_read;
                        read_addr <= next_shift[6:0];
                        read_req_toggle <= ~read_req_toggle;
                    end
                    else if (last_bit)
                    begin
                        phase <= ph_write;
                    end
                end
                // write data is consumed and dropped: nothing is writable
                ph_read, ph_write:
                begin
                    if (last_bit)
                    begin
                        phase <= ph_addr;
                    end
                end
                default:
                begin
                    phase <= ph_addr;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data driven on falling edges, msb first
    always_ff @(negedge sclk)
    begin
        if (link_rst)
        begin
            sdio_oe <= 1'b0;
            sdio_out <= 1'b0;
        end
        else if (phase == ph_read)
        begin
            sdio_oe <= 1'b1;
            sdio_out <= read_data[out_index];
        end
        else
        begin
            sdio_oe <= 1'b0;
            sdio_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### core/motion_sensor_id_status_regs.sv
// identification and motion status registers behind the serial link
`timescale 1ns/10ps
`default_nettype none

module motion_sensor_id_status_regs
    import sensor_regs_pkg::*;
#(
    // arbitrary value, not any real part's identifier
    parameter logic [PART_ID_WIDTH-1:0] PART_IDENTIFIER = 12'ha5c
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    input wire logic move_valid,
    input wire logic [7:0] move_dx,
    input wire logic [7:0] move_dy,
    input wire logic [2:0] resolution_code,
    output logic motion_pending
);

    ////////////////////////////////////////////////////////////////////////
    // link end on the host clock

    logic [6:0] read_addr;
    logic read_req_toggle;
    logic [7:0] read_data;

    serial_link link_end (
        .sclk(sclk),
        .rst(rst),
        .sdio_in(sdio_in),
        .sdio_out(sdio_out),
        .sdio_oe(sdio_oe),
        .read_addr(read_addr),
        .read_req_toggle(read_req_toggle),
        .read_data(read_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // read request crossing: toggle through two flops, then edge
    // read_data is only launched onto the link after the host's wait,
    // so the captured byte has settled long before sclk samples it

    logic req_meta;
    logic req_sync;
    logic req_seen;

    // third flop keeps the last level so one toggle is one pulse
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_seen <= 1'b0;
        end
        else
        begin
            req_meta <= read_req_toggle;
            req_sync <= req_meta;
            req_seen <= req_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode and clear strobes

    // address is held by the link end until the next frame
    wire logic read_pulse = req_sync ^ req_seen;
    wire logic hit_id_high = (read_addr == ADDR_PART_ID_HIGH_BYTE);
    wire logic hit_id_low = (read_addr == ADDR_PART_ID_LOW_NIBBLE);
    wire logic hit_flags = (read_addr == ADDR_MOVEMENT_FLAGS);
    wire logic hit_dx = (read_addr == ADDR_DELTA_X);
    wire logic hit_dy = (read_addr == ADDR_DELTA_Y);

    wire logic [AXIS_COUNT-1:0] clear_axis =
        {read_pulse & hit_dy, read_pulse & hit_dx};
    wire logic clear_motion = |clear_axis;

    ////////////////////////////////////////////////////////////////////////
    // delta accumulators, one per axis

    wire logic [AXIS_COUNT-1:0][7:0] step = {move_dy, move_dx};
    // unpacked so that each axis process owns its own element
    logic [7:0] delta [AXIS_COUNT];
    logic overflow [AXIS_COUNT];

    genvar axis;
    generate
        for (axis = 0; axis < AXIS_COUNT; axis = axis + 1)
        begin : g_axis
            // a read in the same cycle restarts the count from this step
            wire logic [7:0] base =
                clear_axis[axis] ? DELTA_RESET : delta[axis];
            wire logic [8:0] sum =
                {base[7], base} + {step[axis][7], step[axis]};
            wire logic over_now = sum[8] ^ sum[7];
            // saturate rather than wrap so the sign of a fast move survives
            wire logic [7:0] saturated = ~over_now ? sum[7:0] :
                (sum[8] ? DELTA_MOST_NEGATIVE : DELTA_MOST_POSITIVE);
            wire logic kept_flag = overflow[axis] & ~clear_axis[axis];
            // a move always loads, otherwise a read may clear
            wire logic [7:0] next_delta =
                move_valid ? saturated : base;
            wire logic next_overflow =
                move_valid ? (kept_flag | over_now) : kept_flag;

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    delta[axis] <= DELTA_RESET;
                    overflow[axis] <= 1'b0;
                end
                else
                begin
                    delta[axis] <= next_delta;
                    overflow[axis] <= next_overflow;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // motion flag

    wire logic moved = move_valid & ((|move_dx) | (|move_dy));
    logic motion;
    // new movement wins over a clearing read
    wire logic next_motion = moved | (motion & ~clear_motion);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            motion <= 1'b0;
        end
        else
        begin
            motion <= next_motion;
        end
    end

    // status bit 7 also leaves the block as a level
    assign motion_pending = motion;

    ////////////////////////////////////////////////////////////////////////
    // resolution code, copied each cycle from the configuration logic

    logic [RESOLUTION_WIDTH-1:0] resolution;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            resolution <= RESOLUTION_RESET;
        end
        else
        begin
            resolution <= resolution_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read selection

    wire logic [3:0] part_identifier_low =
        PART_IDENTIFIER[PART_ID_LOW_MSB:0];
    wire logic x_overflow_flag = overflow[AXIS_X];
    wire logic y_overflow_flag = overflow[AXIS_Y];
    wire logic [7:0] delta_x_byte = delta[AXIS_X];
    wire logic [7:0] delta_y_byte = delta[AXIS_Y];

    wire logic [7:0] id_high_byte =
        PART_IDENTIFIER[PART_ID_HIGH_MSB:PART_ID_HIGH_LSB];
    wire logic [7:0] id_low_byte =
        {part_identifier_low, PART_ID_RESERVED_NIBBLE};
    wire logic [7:0] flags_byte = {
        motion,
        FLAGS_RESERVED,
        y_overflow_flag,
        x_overflow_flag,
        resolution
    };

    wire logic [7:0] selected_byte =
        hit_id_high ? id_high_byte :
        hit_id_low ? id_low_byte :
        hit_flags ? flags_byte :
        hit_dx ? delta_x_byte :
        hit_dy ? delta_y_byte :
        UNMAPPED_READ_VALUE;

    // captured word stays put until the next read request
    wire logic [7:0] next_read_data =
        read_pulse ? selected_byte : read_data;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            read_data <= UNMAPPED_READ_VALUE;
        end
        else
        begin
            read_data <= next_read_data;
        end
    end

endmodule

`default_nettype wire

// ### sim/motion_regs_asserts.sv
// checker for the motion flag and the link answer window
`timescale 1ns/10ps
`default_nettype none

module motion_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdio_oe,
    input wire logic move_valid,
    input wire logic [7:0] move_dx,
    input wire logic [7:0] move_dy,
    input wire logic motion_pending
);
    a_pending_reset: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> !motion_pending)
        else $error("motion flag up after reset");
    a_pending_sets: assert property (@(posedge clk) disable iff (rst)
        (move_valid && (move_dx != 8'h00 || move_dy != 8'h00))
        |-> ##[1:2] motion_pending)
        else $error("motion flag missed a move");
    a_pending_idle: assert property (@(posedge clk) disable iff (rst)
        (!motion_pending && !move_valid && !$past(move_valid))
        |=> !motion_pending)
        else $error("motion flag rose without a move");
    a_zero_move: assert property (@(posedge clk) disable iff (rst)
        (move_valid && move_dx == 8'h00 && move_dy == 8'h00
        && !motion_pending && !$past(move_valid)) |=> !motion_pending)
        else $error("motion flag rose on a zero step");
    a_oe_span: assert property (@(negedge sclk) disable iff (rst)
        $rose(sdio_oe) |-> sdio_oe[*8] ##1 !sdio_oe)
        else $error("answer window not eight bits");
    a_oe_gap: assert property (@(negedge sclk) disable iff (rst)
        $fell(sdio_oe) |-> !sdio_oe[*8])
        else $error("device drove during address byte");
endmodule

bind motion_sensor_id_status_regs motion_regs_chk chk (.clk(clk),
    .rst(rst), .sclk(sclk), .sdio_oe(sdio_oe), .move_valid(move_valid),
    .move_dx(move_dx), .move_dy(move_dy), .motion_pending(motion_pending));

`default_nettype wire

// ### sim/link_host.sv
// host model on the serial link: makes sclk and frames transfers
`timescale 1ns/10ps
`default_nettype none

module link_host (
    output logic sclk,
    output logic sdio_line,
    input wire logic sdio_out,
    input wire logic sdio_oe
);
    logic drv;

    assign sdio_line = sdio_oe ? sdio_out : drv;

    initial
    begin
        sclk = 1'b0;
        drv = 1'b0;
    end

    // bare clock pulses while reset settles
    task automatic pulses(input int n);
        repeat (n)
        begin
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
        end
    endtask

    // one frame of 16 sclk pulses (32 edges), sclk idles low
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rd);
        int i;
        rd = 8'h00;
        for (i = 7; i >= 0; i--)
        begin
            drv = cmd[i];
            #6 sclk = 1'b1;
            if (i == 0 && !cmd[7])
                #600;
            #6 sclk = 1'b0;
        end
        for (i = 7; i >= 0; i--)
        begin
            // released line wanders, never holds the last bit
            drv = cmd[7] ? wd[i] : ~drv;
            #6 sclk = 1'b1;
            rd[i] = sdio_line;
            #6 sclk = 1'b0;
        end
        #6;
    endtask
endmodule

`default_nettype wire

// ### sim/tb_top.sv
// bench for the id and status registers over the serial link
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
        n_mismatch++; \
        $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end

module tb_top;
    logic clk, rst, move_valid, sclk, sdio_line, sdio_out, sdio_oe, pend;
    logic [7:0] move_dx, move_dy, got;
    logic [2:0] res_code;
    int n_mismatch = 0;
    int tests_run = 0;
    int k;

    motion_sensor_id_status_regs #(.PART_IDENTIFIER(12'ha5c)) uut (
        .clk(clk), .rst(rst), .sclk(sclk), .sdio_in(sdio_line),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .move_valid(move_valid),
        .move_dx(move_dx), .move_dy(move_dy),
        .resolution_code(res_code), .motion_pending(pend));

    link_host host (.sclk(sclk), .sdio_line(sdio_line),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe));

    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer({1'b0, a}, 8'h00, got);
        `CHK("register read", e, got)
    endtask

    task automatic move(input logic [7:0] dx, input logic [7:0] dy);
        @(posedge clk);
        move_valid <= 1'b1;
        move_dx <= dx;
        move_dy <= dy;
        @(posedge clk);
        move_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        #1_000_000;
        n_mismatch++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        move_valid = 1'b0;
        move_dx = 8'h00;
        move_dy = 8'h00;
        res_code = 3'b100;
        repeat (4) @(posedge clk);
        host.pulses(4);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        host.pulses(2);
        `CHK("motion_pending", 1'b0, pend)
        rd(7'h00, 8'ha5);
        rd(7'h01, 8'hc0);
        rd(7'h02, 8'h04);
        host.xfer(8'h80, 8'hff, got);
        host.xfer(8'h81, 8'h0f, got);
        rd(7'h00, 8'ha5);
        rd(7'h01, 8'hc0);
        rd(7'h7f, 8'h00);
        for (k = 0; k < 6; k++)
        begin
            @(posedge clk);
            res_code <= 3'(k);
            repeat (2) @(posedge clk);
            rd(7'h02, {5'h00, 3'(k)});
        end
        move(8'h00, 8'h00);
        `CHK("motion_pending", 1'b0, pend)
        move(8'h05, 8'h00);
        `CHK("motion_pending", 1'b1, pend)
        rd(7'h02, 8'h85);
        move(8'hfe, 8'h00);
        rd(7'h03, 8'h03);
        rd(7'h03, 8'h00);
        rd(7'h02, 8'h05);
        `CHK("motion_pending", 1'b0, pend)
        move(8'h7f, 8'h00);
        move(8'h01, 8'h00);
        rd(7'h02, 8'h8d);
        rd(7'h03, 8'h7f);
        rd(7'h02, 8'h05);
        move(8'h00, 8'h80);
        move(8'h00, 8'hff);
        rd(7'h02, 8'h95);
        rd(7'h04, 8'h80);
        rd(7'h02, 8'h05);
        give_verdict();
    end
endmodule

`default_nettype wire
